// file: verilog/gpupd_pkg.sv
package gpupd_pkg;

	// ----------------------------------------------------------------
	// Register map (word offsets chosen for this block)
	// ----------------------------------------------------------------
	localparam logic [3:0] GPUPD_OFS_A_PUD = 4'h0;   // Port A pull-up disable.
	localparam logic [3:0] GPUPD_OFS_B_PUD = 4'h1;   // Port B pull-up disable.
	localparam logic [3:0] GPUPD_OFS_A_DAT = 4'h2;   // Port A pin data.
	localparam logic [3:0] GPUPD_OFS_B_DAT = 4'h3;   // Port B pin data.
	localparam logic [3:0] GPUPD_OFS_AIO_DAT = 4'h4; // Analog pin data.
	localparam logic [3:0] GPUPD_OFS_A_DIR = 4'h5;   // Port A direction.
	localparam logic [3:0] GPUPD_OFS_B_DIR = 4'h6;   // Port B direction.
	localparam logic [3:0] GPUPD_OFS_AIO_DIR = 4'h7; // Analog direction.

	// ----------------------------------------------------------------
	// Implemented bits and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] GPUPD_A_MASK = 32'hFFFF_FFFF;   // All port A bits.
	localparam logic [31:0] GPUPD_B_MASK = 32'h07FC_1FFF;   // Bits 26-18 and 12-0.
	localparam logic [31:0] GPUPD_AIO_MASK = 32'h0000_5454; // Bits 2,4,6,10,12,14.
	localparam logic [31:0] GPUPD_A_PUD_RST = 32'h0000_0FFF; // Pins 0-11 off.
	localparam logic [31:0] GPUPD_B_PUD_RST = 32'h0000_0F00; // Pins 40-43 off.
	localparam logic [31:0] GPUPD_PWM_PINS = 32'h0000_0FFF;  // Pulse-width pins 0-11.
	localparam logic [31:0] GPUPD_ZERO = 32'h0000_0000;      // Clear value.

endpackage

// file: verilog/gpupd_sync.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Two-flop synchroniser for a vector of pin levels
// ----------------------------------------------------------------
module gpupd_sync #(
	parameter int WIDTH = 32
) (
	input  wire logic             clk,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	// First stage; only the second stage reads it.
	logic [WIDTH-1:0] meta_q;

	// A zero-width vector has nothing to synchronise; refuse it when built.
	if (WIDTH < 1) begin : g_width_check
		$error("gpupd_sync: WIDTH must be positive.");
	end

	// Both stages run free; pin levels need no reset value.
	always_ff @(posedge clk) begin
		meta_q   <= async_in;
		sync_out <= meta_q;
	end
endmodule

// file: verilog/gpupd_top.sv
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps

// Operation
// - Pulse-width pins pull-ups off while external reset low
// - Other pins reset with pull-up enabled; port B 40-43 reset disabled
// - Pull-up changes only by software write
// - Pull-up applies in every pin function
// - Port A disable bits, 0-11 reset one
// - Port B disable bits, 40-43 reset one
// - Data read returns qualified pin level
// - Data write loads latch, drives if output
// - Latch holds until next write
// - Reset clears latches to zero
// - Port A read follows pin after reset
// - Bit n maps pin n, port B packed
// - Analog register implements six pins only
// - Direction zero input, one output, reset input
module gpupd_top
	import gpupd_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RESETN,
	input  wire logic        EXTERNAL_RESET_N,
	input  wire logic [3:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [31:0] RDATA,
	input  wire logic [31:0] PORT_A_FUNCTION_SELECT,
	input  wire logic [31:0] PORT_B_FUNCTION_SELECT,
	input  wire logic [31:0] AIO_FUNCTION_SELECT,
	input  wire logic [31:0] PORT_A_PIN_IN,
	input  wire logic [31:0] PORT_B_PIN_IN,
	input  wire logic [31:0] AIO_PIN_IN,
	output logic      [31:0] PORT_A_PIN_OUT,
	output logic      [31:0] PORT_A_PIN_OE,
	output logic      [31:0] PORT_B_PIN_OUT,
	output logic      [31:0] PORT_B_PIN_OE,
	output logic      [31:0] AIO_PIN_OUT,
	output logic      [31:0] AIO_PIN_OE,
	output logic      [31:0] PORT_A_PULLUP_EN,
	output logic      [31:0] PORT_B_PULLUP_EN
);
	import gpupd_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [31:0] a_pud_q;      // Port A pull-up disable.
	logic [31:0] b_pud_q;      // Port B pull-up disable.
	logic [31:0] a_lat_q;      // Port A output latch.
	logic [31:0] b_lat_q;      // Port B output latch.
	logic [31:0] aio_lat_q;    // Analog output latch.
	logic [31:0] a_dir_q;      // Port A direction.
	logic [31:0] b_dir_q;      // Port B direction.
	logic [31:0] aio_dir_q;    // Analog direction.
	logic [31:0] a_lvl;        // Qualified port A levels.
	logic [31:0] b_lvl;        // Qualified port B levels.
	logic [31:0] aio_lvl;      // Qualified analog levels.
	logic [31:0] rdata_d;      // Next read data.
	logic        xrs_meta_q;   // External reset, first stage.
	logic        xrs_sync_q;   // External reset, synchronised.

	// ----------------------------------------------------------------
	// Input qualification
	// ----------------------------------------------------------------
	// Pins are outside our clock domain, so each passes two flops. The
	// cost is two cycles of read latency, far below any software poll.
	logic [31:0] pin_raw [3];  // Raw pad levels, one word per port.
	logic [31:0] pin_sync [3]; // Synchronised pad levels.

	assign pin_raw[0] = PORT_A_PIN_IN;
	assign pin_raw[1] = PORT_B_PIN_IN;
	assign pin_raw[2] = AIO_PIN_IN;

	// The same two-flop stage serves each port word.
	for (genvar g = 0; g < 3; g++) begin : g_sync
		gpupd_sync #(.WIDTH(32)) gpupd_sync_inst (
			.clk      (CLK),
			.async_in (pin_raw[g]),
			.sync_out (pin_sync[g])
		);
	end

	// Levels as the read port and the assertions see them.
	assign a_lvl   = pin_sync[0];
	assign b_lvl   = pin_sync[1];
	assign aio_lvl = pin_sync[2];

	// Synchronised copy of external reset, used only by assertions.
	always_ff @(posedge CLK) begin
		xrs_meta_q <= EXTERNAL_RESET_N;
		xrs_sync_q <= xrs_meta_q;
	end

	// ----------------------------------------------------------------
	// Pull-up registers
	// ----------------------------------------------------------------
	// Port A pull-up disable: reset default, then only a write changes it.
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			a_pud_q <= GPUPD_A_PUD_RST;
		end else if (WR && ADDR == GPUPD_OFS_A_PUD) begin
			a_pud_q <= WDATA & GPUPD_A_MASK;
		end
	end

	// Port B pull-up disable keeps reserved bits at zero.
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			b_pud_q <= GPUPD_B_PUD_RST;
		end else if (WR && ADDR == GPUPD_OFS_B_PUD) begin
			b_pud_q <= WDATA & GPUPD_B_MASK;
		end
	end

	// Pull-up enables go to the pads whatever the pin function is.
	// The pulse-width pins lose their pull-ups combinationally while the
	// external reset pin is low, so no clock edge is needed to cut them.
	always_comb begin
		PORT_A_PULLUP_EN = ~a_pud_q;
		PORT_B_PULLUP_EN = ~b_pud_q & GPUPD_B_MASK;
		if (!EXTERNAL_RESET_N) begin
			PORT_A_PULLUP_EN = PORT_A_PULLUP_EN & ~GPUPD_PWM_PINS;
		end
	end

	// ----------------------------------------------------------------
	// Direction registers
	// ----------------------------------------------------------------
	// Direction: zero is input, and input is the reset state.
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			a_dir_q   <= GPUPD_ZERO;
			b_dir_q   <= GPUPD_ZERO;
			aio_dir_q <= GPUPD_ZERO;
		end else if (WR) begin
			case (ADDR)
				GPUPD_OFS_A_DIR: begin
					a_dir_q <= WDATA & GPUPD_A_MASK;
				end
				GPUPD_OFS_B_DIR: begin
					b_dir_q <= WDATA & GPUPD_B_MASK;
				end
				GPUPD_OFS_AIO_DIR: begin
					aio_dir_q <= WDATA & GPUPD_AIO_MASK;
				end
				default: begin
					// Other offsets leave direction alone.
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Output latches
	// ----------------------------------------------------------------
	// Each latch loads on a write to its own data register and otherwise
	// holds; a write is stored even when the pin does not drive.
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			a_lat_q   <= GPUPD_ZERO;
			b_lat_q   <= GPUPD_ZERO;
			aio_lat_q <= GPUPD_ZERO;
		end else if (WR) begin
			case (ADDR)
				GPUPD_OFS_A_DAT: begin
					a_lat_q <= WDATA & GPUPD_A_MASK;
				end
				GPUPD_OFS_B_DAT: begin
					b_lat_q <= WDATA & GPUPD_B_MASK;
				end
				GPUPD_OFS_AIO_DAT: begin
					aio_lat_q <= WDATA & GPUPD_AIO_MASK;
				end
				default: begin
					// Not a data register.
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	// A pin drives only as a general-purpose output: function select
	// low means general-purpose, direction high means output. Peripheral
	// drive is muxed in outside this block, so here the enable stays low.
	// The latch still follows every write, so software can preload a level
	// before it turns a pin into an output and avoid a glitch.
	always_comb begin
		PORT_A_PIN_OE = a_dir_q & ~PORT_A_FUNCTION_SELECT;
		PORT_B_PIN_OE = b_dir_q & ~PORT_B_FUNCTION_SELECT & GPUPD_B_MASK;
		AIO_PIN_OE    = aio_dir_q & ~AIO_FUNCTION_SELECT & GPUPD_AIO_MASK;
		PORT_A_PIN_OUT = a_lat_q;
		PORT_B_PIN_OUT = b_lat_q;
		AIO_PIN_OUT    = aio_lat_q;
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	// Data registers return synchronised pin levels, never the latch.
	always_comb begin
		rdata_d = GPUPD_ZERO;
		case (ADDR)
			GPUPD_OFS_A_PUD: begin
				rdata_d = a_pud_q;
			end
			GPUPD_OFS_B_PUD: begin
				rdata_d = b_pud_q & GPUPD_B_MASK;
			end
			GPUPD_OFS_A_DAT: begin
				rdata_d = a_lvl;
			end
			GPUPD_OFS_B_DAT: begin
				rdata_d = b_lvl & GPUPD_B_MASK;
			end
			GPUPD_OFS_AIO_DAT: begin
				rdata_d = aio_lvl & GPUPD_AIO_MASK;
			end
			GPUPD_OFS_A_DIR: begin
				rdata_d = a_dir_q;
			end
			GPUPD_OFS_B_DIR: begin
				rdata_d = b_dir_q;
			end
			GPUPD_OFS_AIO_DIR: begin
				rdata_d = aio_dir_q;
			end
			default: begin
				// Unmapped offsets read zero.
				rdata_d = GPUPD_ZERO;
			end
		endcase
	end

	// Read data stands one cycle after the strobe and is zero otherwise.
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			RDATA <= GPUPD_ZERO;
		end else if (RD) begin
			RDATA <= rdata_d;
		end else begin
			RDATA <= GPUPD_ZERO;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Hold and write properties also test the sampled reset: a reset edge
	// changes state while the current reset value already reads high, and
	// the disable alone would let such an attempt through.
	pwm_pullup_off_a: assert property (
		@(posedge CLK) !EXTERNAL_RESET_N |-> (PORT_A_PULLUP_EN & GPUPD_PWM_PINS) == 32'h0000_0000)
		else $error("Pulse-width pull-ups on during external reset.");

	reset_pullup_a: assert property (
		@(posedge CLK) !RESETN |=> (PORT_A_PULLUP_EN[31:12] == 20'hF_FFFF)
			&& (PORT_B_PULLUP_EN == 32'h07FC_10FF))
		else $error("Pull-up reset defaults wrong.");

	pud_hold_a: assert property (
		@(posedge CLK) disable iff (!RESETN)
		RESETN && !(WR && ADDR == GPUPD_OFS_A_PUD) |=> $stable(a_pud_q))
		else $error("Pull-up changed without a write.");

	pud_write_a: assert property (
		@(posedge CLK) disable iff (!RESETN)
		(RESETN && WR && ADDR == GPUPD_OFS_A_PUD) |=> a_pud_q == $past(WDATA))
		else $error("Port A pull-up write lost.");

	b_reserved_zero_a: assert property (
		@(posedge CLK) disable iff (!RESETN)
		(b_pud_q & ~GPUPD_B_MASK) == 32'h0000_0000)
		else $error("Port B reserved pull-up bit set.");

	read_level_a: assert property (
		@(posedge CLK) disable iff (!RESETN)
		(RESETN && RD && ADDR == GPUPD_OFS_A_DAT) |=> RDATA == $past(a_lvl))
		else $error("Data read not pin level.");

	drive_gating_a: assert property (
		@(posedge CLK) disable iff (!RESETN)
		(RESETN && WR && ADDR == GPUPD_OFS_A_DAT)
			##1 (a_dir_q[0] && !PORT_A_FUNCTION_SELECT[0])
			|-> PORT_A_PIN_OE[0] && PORT_A_PIN_OUT[0] == $past(WDATA[0]))
		else $error("Output pin not driven with latch.");

	latch_hold_a: assert property (
		@(posedge CLK) disable iff (!RESETN)
		RESETN && !(WR && ADDR == GPUPD_OFS_B_DAT) |=> $stable(b_lat_q))
		else $error("Port B latch changed without a write.");

	aio_bits_a: assert property (
		@(posedge CLK) (AIO_PIN_OE & ~GPUPD_AIO_MASK) == 32'h0000_0000)
		else $error("Unimplemented analog pin driven.");

	input_no_drive_a: assert property (
		@(posedge CLK) disable iff (!RESETN)
		((~a_dir_q | PORT_A_FUNCTION_SELECT) & PORT_A_PIN_OE) == 32'h0000_0000)
		else $error("Non-output pin driven.");

	latch_reset_a: assert property (
		@(posedge CLK) !RESETN
			|=> (PORT_A_PIN_OUT | PORT_B_PIN_OUT | AIO_PIN_OUT) == 32'h0000_0000)
		else $error("Output latch not cleared by reset.");

	dir_reset_a: assert property (
		@(posedge CLK) !RESETN
			|=> (PORT_A_PIN_OE | PORT_B_PIN_OE | AIO_PIN_OE) == 32'h0000_0000)
		else $error("Pin driven right after reset.");

	b_read_zero_a: assert property (
		@(posedge CLK) disable iff (!RESETN)
		(RESETN && RD && ADDR == GPUPD_OFS_B_DAT)
			|=> (RDATA & ~GPUPD_B_MASK) == 32'h0000_0000)
		else $error("Port B reserved read bit set.");

	// Synchronised external reset checked against the pulse-width pull-ups.
	xrs_sync_a: assert property (
		@(posedge CLK) !xrs_sync_q |-> (PORT_A_PULLUP_EN[11:0] == 12'h000) || EXTERNAL_RESET_N)
		else $error("Pull-up on while external reset held.");
endmodule

// file: tb/gpupd_pads.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Pad model: device driver, outside driver, pull-up, floating
// ----------------------------------------------------------------
module gpupd_pads (
	input  wire logic        clk,
	input  wire logic [31:0] drv_out,
	input  wire logic [31:0] drv_oe,
	input  wire logic [31:0] pull_en,
	input  wire logic [31:0] ext_val,
	input  wire logic [31:0] ext_en,
	output logic      [31:0] level
);
	// A floating pad wanders each cycle, so a stale value never passes.
	logic [31:0] float_q = 32'h0000_0000;

	always @(posedge clk) begin
		float_q <= ~float_q;
	end

	// pull-up in any mode: the pull-up acts whatever the pin function.
	assign level = (drv_oe & drv_out) | (~drv_oe & ext_en & ext_val)
		| (~drv_oe & ~ext_en & pull_en) | (~drv_oe & ~ext_en & ~pull_en & float_q);
endmodule

// file: tb/test_gpupd_top.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Register and pad level tests
// ----------------------------------------------------------------
module test_gpupd_top;
	import gpupd_pkg::*;

	logic        clk = 1'b0;                 // System clock.
	logic        resetn = 1'b0;              // Block reset.
	logic        ext_rst_n = 1'b1;           // Outside reset pin.
	logic [3:0]  addr = 4'h0;                // Register index.
	logic [31:0] wdata = 32'h0000_0000;      // Write data.
	logic        wr = 1'b0;                  // Write strobe.
	logic        rd = 1'b0;                  // Read strobe.
	logic [31:0] rdata;                      // Read data.
	logic [31:0] fsel_a = 32'h0000_0000;     // Function selects.
	logic [31:0] fsel_b = 32'h0000_0000;
	logic [31:0] fsel_c = 32'h0000_0000;
	logic [31:0] ev_a = 32'hA5A5_0F0F;       // Outside drive values.
	logic [31:0] ev_b = 32'h0555_1234;
	logic [31:0] ev_c = 32'hFFFF_FFFF;
	logic [31:0] ee_a = 32'hFFFF_FFFF;       // Outside drive enables.
	logic [31:0] ee_c = 32'hFFFF_FFFF;
	logic [31:0] in_a, in_b, in_c, out_a, out_b, out_c, oe_a, oe_b, oe_c, pu_a, pu_b;
	int          fails = 0;
	int          total_checks = 0;
	int          cycles = 0;

	always #12.5 clk = ~clk;

	gpupd_top gpupd_top_inst (.CLK(clk), .RESETN(resetn), .EXTERNAL_RESET_N(ext_rst_n),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.PORT_A_FUNCTION_SELECT(fsel_a), .PORT_B_FUNCTION_SELECT(fsel_b),
		.AIO_FUNCTION_SELECT(fsel_c), .PORT_A_PIN_IN(in_a), .PORT_B_PIN_IN(in_b),
		.AIO_PIN_IN(in_c), .PORT_A_PIN_OUT(out_a), .PORT_A_PIN_OE(oe_a),
		.PORT_B_PIN_OUT(out_b), .PORT_B_PIN_OE(oe_b), .AIO_PIN_OUT(out_c),
		.AIO_PIN_OE(oe_c), .PORT_A_PULLUP_EN(pu_a), .PORT_B_PULLUP_EN(pu_b));

	// Port B is always driven from outside; the analog pins have no pull-up.
	gpupd_pads pads_a (.clk(clk), .drv_out(out_a), .drv_oe(oe_a), .pull_en(pu_a),
		.ext_val(ev_a), .ext_en(ee_a), .level(in_a));
	gpupd_pads pads_b (.clk(clk), .drv_out(out_b), .drv_oe(oe_b), .pull_en(pu_b),
		.ext_val(ev_b), .ext_en(32'hFFFF_FFFF), .level(in_b));
	gpupd_pads pads_c (.clk(clk), .drv_out(out_c), .drv_oe(oe_c), .pull_en(32'h0000_0000),
		.ext_val(ev_c), .ext_en(ee_c), .level(in_c));

	// Prints the verdict and ends the run.
	task automatic complete_run();
		if (fails == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Compares one value and reports a mismatch.
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One-cycle write; returns just after the edge that takes it.
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	// One-cycle read; the data stand only in the following cycle.
	task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("rdata", rdata, exp);
	endtask

	// Lets pad changes pass the input synchroniser.
	task automatic settle();
		repeat (4) @(posedge clk);
	endtask

	// A hung run is cut short well past the expected length.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		settle();
		rd_reg(GPUPD_OFS_A_PUD, GPUPD_A_PUD_RST);
		rd_reg(GPUPD_OFS_B_PUD, GPUPD_B_PUD_RST);
		chk("pu_a", pu_a, ~GPUPD_A_PUD_RST);
		chk("pu_b", pu_b & GPUPD_B_MASK, ~GPUPD_B_PUD_RST & GPUPD_B_MASK);
		chk("out_a", out_a, GPUPD_ZERO);
		chk("oe_a", oe_a | oe_b | oe_c, GPUPD_ZERO);
		// data register reads serve as pin level polls.
		rd_reg(GPUPD_OFS_A_DAT, ev_a);
		rd_reg(GPUPD_OFS_B_DAT, ev_b & GPUPD_B_MASK);
		wr_reg(GPUPD_OFS_A_PUD, GPUPD_ZERO);
		chk("pu_a", pu_a, 32'hFFFF_FFFF);
		@(posedge clk);
		ext_rst_n <= 1'b0;
		#1;
		chk("pu_a", pu_a, ~GPUPD_PWM_PINS);
		@(posedge clk);
		ext_rst_n <= 1'b1;
		// software keeps reserved bits at zero in every write below.
		wr_reg(GPUPD_OFS_B_PUD, GPUPD_B_MASK);
		rd_reg(GPUPD_OFS_B_PUD, GPUPD_B_MASK);
		chk("pu_b", pu_b, GPUPD_ZERO);
		// Latch loads while the pins stay inputs; reads show the pads.
		wr_reg(GPUPD_OFS_A_DAT, 32'h1234_5678);
		chk("out_a", out_a, 32'h1234_5678);
		chk("oe_a", oe_a, GPUPD_ZERO);
		rd_reg(GPUPD_OFS_A_DAT, ev_a);
		wr_reg(GPUPD_OFS_B_DAT, GPUPD_B_MASK);
		chk("out_b", out_b, GPUPD_B_MASK);
		// Upper port A pins serve a peripheral; lower ones stay general purpose.
		@(posedge clk);
		fsel_a <= 32'hFFFF_0000;
		ee_a <= 32'hFFFF_0000;
		wr_reg(GPUPD_OFS_A_DIR, 32'hFFFF_FFFF);
		chk("oe_a", oe_a, 32'h0000_FFFF);
		chk("out_a", out_a, 32'h1234_5678);
		settle();
		rd_reg(GPUPD_OFS_A_DAT, 32'hA5A5_5678);
		wr_reg(GPUPD_OFS_A_DAT, 32'h0000_0001);
		settle();
		rd_reg(GPUPD_OFS_A_DAT, 32'hA5A5_0001);
		rd_reg(GPUPD_OFS_A_DIR, 32'hFFFF_FFFF);
		// Released pins float up through the pull-ups, peripheral or not.
		@(posedge clk);
		ee_a <= GPUPD_ZERO;
		wr_reg(GPUPD_OFS_A_DIR, GPUPD_ZERO);
		settle();
		rd_reg(GPUPD_OFS_A_DAT, 32'hFFFF_FFFF);
		// Port B drives its packed pins; the outside sets a reserved bit.
		wr_reg(GPUPD_OFS_B_DIR, GPUPD_B_MASK);
		chk("oe_b", oe_b, GPUPD_B_MASK);
		rd_reg(GPUPD_OFS_B_DIR, GPUPD_B_MASK);
		settle();
		rd_reg(GPUPD_OFS_B_DAT, GPUPD_B_MASK);
		@(posedge clk);
		fsel_b <= GPUPD_B_MASK;
		#1;
		chk("oe_b", oe_b, GPUPD_ZERO);
		// Analog pins: reserved pad levels are high and must read zero.
		wr_reg(GPUPD_OFS_AIO_DAT, 32'h0000_1044);
		chk("out_c", out_c, 32'h0000_1044);
		wr_reg(GPUPD_OFS_AIO_DIR, GPUPD_AIO_MASK);
		chk("oe_c", oe_c, GPUPD_AIO_MASK);
		rd_reg(GPUPD_OFS_AIO_DIR, GPUPD_AIO_MASK);
		settle();
		rd_reg(GPUPD_OFS_AIO_DAT, 32'h0000_1044);
		@(posedge clk);
		#1;
		chk("rdata", rdata, GPUPD_ZERO);
		@(posedge clk);
		fsel_c <= GPUPD_AIO_MASK;
		#1;
		chk("oe_c", oe_c, GPUPD_ZERO);
		rd_reg(4'hF, GPUPD_ZERO);
		@(posedge clk);
		resetn <= 1'b0;
		@(posedge clk);
		resetn <= 1'b1;
		#1;
		chk("out_a", out_a | out_b | out_c, GPUPD_ZERO);
		chk("oe_a", oe_a | oe_b | oe_c, GPUPD_ZERO);
		rd_reg(GPUPD_OFS_A_PUD, GPUPD_A_PUD_RST);
		rd_reg(GPUPD_OFS_B_PUD, GPUPD_B_PUD_RST);
		complete_run();
	end
endmodule
